// ### rtl/emp_pkg.sv
// Constants, types and pin groups of the external memory port.
// Assumes a 20 MHz reference clock; all phase lengths are derived from it.
package emp_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int ROW_PHASE_NS = 100;
	localparam int COL_PHASE_NS = 100;
	localparam int PRECHARGE_NS = 100;
	localparam int SETUP_NS = 50;
	localparam int STROBE_NS = 150;
	localparam int RECOVER_NS = 50;
	localparam logic [2:0] ROW_CYCLES = 3'((ROW_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] COL_CYCLES = 3'((COL_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] PRE_CYCLES = 3'((PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] SETUP_CYCLES = 3'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] STROBE_CYCLES = 3'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] RECOVER_CYCLES = 3'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] ECHO_CYCLES = 3'h3;

	// ==========================================================
	// Master fields carried on the DRAM address pins
	localparam int MA_HIGH_POS = 9;
	localparam int MA_BURST_POS = 3;
	localparam int MA_SIZE_POS = 1;
	localparam int MA_RNW_POS = 0;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_HALF = 2'h2;
	localparam logic [1:0] SIZE_BAD = 2'h3;

	// ==========================================================
	// Reset values
	localparam logic [3:0] LANES_IDLE = 4'hf;
	localparam logic [5:0] ROWS_IDLE = 6'h3f;
	localparam logic [1:0] SPECIAL_IDLE = 2'h3;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		KIND_DRAM = 3'h0,
		KIND_SRAM = 3'h1,
		KIND_EXT_IO = 3'h2,
		KIND_ROM = 3'h3,
		KIND_SPECIAL = 3'h4
	} emp_kind_t;

	typedef struct packed {
		emp_kind_t kind;
		logic write;
		logic [2:0] bank;
		logic special_sel;
		logic [3:0] byte_en;
		logic [12:0] row;
		logic [12:0] col;
		logic [23:0] addr;
	} emp_cmd_t;

	typedef struct packed {
		logic [27:0] addr;
		logic burst;
		logic read_not_write;
		logic [1:0] size;
	} emp_master_t;

	typedef struct packed {
		logic [23:0] static_addr;
		logic static_addr_oe;
		logic static_output_enable_n;
		logic [3:0] byte_write_enable_n;
		logic [12:0] dram_addr;
		logic dram_addr_oe;
		logic [5:0] row_strobe_n;
		logic [3:0] column_strobe_n;
		logic dram_output_enable_n;
		logic dram_write_enable_n;
		logic [1:0] special_io_read_n;
		logic [1:0] special_io_write_n;
		logic master_data_latch_n;
		logic master_data_latch_oe;
		logic bus_hold_grant;
	} emp_pins_t;

endpackage

// ### rtl/emp_port.sv
// External memory port: DRAM, static memory and special I/O sequencing plus
// bus takeover by an external master.
// Assumes internal commands on REF_CLK_IN; all pin inputs are asynchronous.
//
// Overview of operation
// - Byte write enables low during static writes, except writes to ROM or special I/O
// - Byte pins show master byte latches
// - Drive 13-bit DRAM address on accesses
// - Master mode: DRAM pins input, upper address
// - Size code: 00 byte, 10 half
// - Six banks, one row strobe each
// - Column strobes select byte lanes
// - DRAM output enable low on reads
// - DRAM write enable low on writes
// - Two special read strobes, address latched
// - Two special write strobes, address latched
// - Grant shows bus released to master
// - Data latch line exchanged with master
// - Static address pins carry lower 24 bits
// - Shared output enable on static reads
`timescale 1ns/1ps
`default_nettype none

module emp_port (
	input wire logic REF_CLK_IN,
	input wire logic RESETN_IN,
	input wire logic ACC_REQ_IN,
	input wire emp_pkg::emp_cmd_t ACC_CMD_IN,
	output logic ACC_READY_OUT,
	output logic ACC_DONE_OUT,
	output logic MASTER_REQ_VALID_OUT,
	output emp_pkg::emp_master_t MASTER_REQ_OUT,
	output logic MASTER_SIZE_ERROR_OUT,
	input wire logic MASTER_DONE_IN,
	input wire logic BUS_HOLD_REQUEST_IN,
	output logic BUS_HOLD_GRANT_OUT,
	input wire logic [23:0] STATIC_ADDR_IN,
	output logic [23:0] STATIC_ADDR_OUT,
	output logic STATIC_ADDR_OE_OUT,
	output logic STATIC_OUTPUT_ENABLE_N_OUT,
	output logic [3:0] BYTE_WRITE_ENABLE_N_OUT,
	input wire logic [12:0] DRAM_ADDR_IN,
	output logic [12:0] DRAM_ADDR_OUT,
	output logic DRAM_ADDR_OE_OUT,
	output logic [5:0] ROW_STROBE_N_OUT,
	output logic [3:0] COLUMN_STROBE_N_OUT,
	output logic DRAM_OUTPUT_ENABLE_N_OUT,
	output logic DRAM_WRITE_ENABLE_N_OUT,
	output logic [1:0] SPECIAL_IO_READ_N_OUT,
	output logic [1:0] SPECIAL_IO_WRITE_N_OUT,
	input wire logic MASTER_DATA_LATCH_N_IN,
	output logic MASTER_DATA_LATCH_N_OUT,
	output logic MASTER_DATA_LATCH_OE_OUT
);

	// ==========================================================
	// Declarations
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ROW = 4'h1,
		ST_COL = 4'h2,
		ST_PRE = 4'h3,
		ST_SETUP = 4'h4,
		ST_STROBE = 4'h5,
		ST_RECOVER = 4'h6,
		ST_HOLD = 4'h7,
		ST_MSTR_WAIT = 4'h8,
		ST_MSTR_LATCH = 4'h9,
		ST_RELEASE = 4'ha
	} emp_state_t;

	emp_state_t state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	emp_pkg::emp_cmd_t cmd_reg, cmd_next;
	emp_pkg::emp_master_t mreq_reg, mreq_next;
	emp_pkg::emp_pins_t pins_reg, pins_next;
	logic ready_reg, ready_next;
	logic done_reg, done_next;
	logic mvalid_reg, mvalid_next;
	logic merr_reg, merr_next;
	logic [3:0] lanes_next;

	// Two-flop synchronisers; the latch line has a third stage, compared with the second to find its fall
	logic hold_s1_reg, hold_s2_reg;
	logic dl_s1_reg, dl_s2_reg, dl_s3_reg;
	logic [12:0] da_s1_reg, da_s2_reg;
	logic [23:0] xa_s1_reg, xa_s2_reg;
	logic dl_fall;
	logic [1:0] size_in;

	// ==========================================================
	// Input synchronisers
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			hold_s1_reg <= 1'b0;
			hold_s2_reg <= 1'b0;
			dl_s1_reg <= 1'b1;
			dl_s2_reg <= 1'b1;
			dl_s3_reg <= 1'b1;
			da_s1_reg <= 13'h0000;
			da_s2_reg <= 13'h0000;
			xa_s1_reg <= 24'h000000;
			xa_s2_reg <= 24'h000000;
		end else begin
			hold_s1_reg <= BUS_HOLD_REQUEST_IN;
			hold_s2_reg <= hold_s1_reg;
			dl_s1_reg <= MASTER_DATA_LATCH_N_IN;
			dl_s2_reg <= dl_s1_reg;
			dl_s3_reg <= dl_s2_reg;
			da_s1_reg <= DRAM_ADDR_IN;
			da_s2_reg <= da_s1_reg;
			xa_s1_reg <= STATIC_ADDR_IN;
			xa_s2_reg <= xa_s1_reg;
		end
	end

	// Master starts an access by pulling the latch line low while we listen
	assign dl_fall = dl_s3_reg & ~dl_s2_reg;
	assign size_in = da_s2_reg[emp_pkg::MA_SIZE_POS +: 2];

	// ==========================================================
	// Sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next = (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : 3'h0;
		cmd_next = cmd_reg;
		mreq_next = mreq_reg;
		done_next = 1'b0;
		mvalid_next = 1'b0;
		merr_next = 1'b0;
		lanes_next = emp_pkg::LANES_IDLE;
		case (state_reg)
			ST_IDLE: begin
				// Hold request wins over a new access; one in flight always ends first
				if (hold_s2_reg) begin
					state_next = ST_HOLD;
				end else if (ACC_REQ_IN && ready_reg) begin
					cmd_next = ACC_CMD_IN;
					if (ACC_CMD_IN.kind == emp_pkg::KIND_DRAM) begin
						state_next = ST_ROW;
						cnt_next = emp_pkg::ROW_CYCLES - 3'h1;
					end else begin
						state_next = ST_SETUP;
						cnt_next = emp_pkg::SETUP_CYCLES - 3'h1;
					end
				end
			end
			ST_ROW: begin
				if (cnt_reg == 3'h0) begin
					state_next = ST_COL;
					cnt_next = emp_pkg::COL_CYCLES - 3'h1;
				end
			end
			ST_COL: begin
				if (cnt_reg == 3'h0) begin
					state_next = ST_PRE;
					cnt_next = emp_pkg::PRE_CYCLES - 3'h1;
				end
			end
			ST_SETUP: begin
				if (cnt_reg == 3'h0) begin
					state_next = ST_STROBE;
					cnt_next = emp_pkg::STROBE_CYCLES - 3'h1;
				end
			end
			ST_STROBE: begin
				if (cnt_reg == 3'h0) begin
					state_next = ST_RECOVER;
					cnt_next = emp_pkg::RECOVER_CYCLES - 3'h1;
				end
			end
			ST_PRE, ST_RECOVER: begin
				if (cnt_reg == 3'h0) begin
					state_next = ST_IDLE;
					done_next = 1'b1;
				end
			end
			ST_HOLD: begin
				if (!hold_s2_reg) begin
					state_next = ST_RELEASE;
				end else if (dl_fall && cnt_reg == 3'h0) begin
					mreq_next.addr = {da_s2_reg[emp_pkg::MA_HIGH_POS +: 4], xa_s2_reg};
					mreq_next.burst = da_s2_reg[emp_pkg::MA_BURST_POS];
					mreq_next.read_not_write = da_s2_reg[emp_pkg::MA_RNW_POS];
					mreq_next.size = size_in;
					if (size_in == emp_pkg::SIZE_BAD) begin
						merr_next = 1'b1;
					end else begin
						mvalid_next = 1'b1;
						state_next = ST_MSTR_WAIT;
					end
				end
			end
			ST_MSTR_WAIT: begin
				// A master access is never cut short by the request dropping
				if (MASTER_DONE_IN) begin
					state_next = ST_MSTR_LATCH;
					case (mreq_reg.size)
						emp_pkg::SIZE_BYTE: lanes_next = ~(4'h1 << mreq_reg.addr[1:0]);
						emp_pkg::SIZE_HALF: lanes_next = mreq_reg.addr[1] ? 4'h3 : 4'hc;
						default: lanes_next = 4'h0;
					endcase
				end
			end
			ST_MSTR_LATCH: begin
				// Our own latch pulse echoes through the synchroniser; blank it
				cnt_next = emp_pkg::ECHO_CYCLES;
				state_next = ST_HOLD;
			end
			ST_RELEASE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		ready_next = (state_next == ST_IDLE) && !hold_s2_reg;
	end

	// ==========================================================
	// Pin values, registered so every output comes from a flop
	always_comb begin
		pins_next = '0;
		pins_next.static_addr = cmd_next.addr;
		pins_next.static_addr_oe = 1'b1;
		pins_next.static_output_enable_n = 1'b1;
		pins_next.byte_write_enable_n = emp_pkg::LANES_IDLE;
		pins_next.dram_addr = cmd_next.row;
		pins_next.dram_addr_oe = 1'b1;
		pins_next.row_strobe_n = emp_pkg::ROWS_IDLE;
		pins_next.column_strobe_n = emp_pkg::LANES_IDLE;
		pins_next.dram_output_enable_n = 1'b1;
		pins_next.dram_write_enable_n = 1'b1;
		pins_next.special_io_read_n = emp_pkg::SPECIAL_IDLE;
		pins_next.special_io_write_n = emp_pkg::SPECIAL_IDLE;
		pins_next.master_data_latch_n = 1'b1;
		pins_next.master_data_latch_oe = 1'b0;
		pins_next.bus_hold_grant = 1'b0;
		case (state_next)
			ST_ROW, ST_COL: begin
				// Banks past the sixth select no row strobe at all
				pins_next.row_strobe_n = ~(6'h01 << cmd_next.bank);
				if (state_next == ST_COL) begin
					pins_next.dram_addr = cmd_next.col;
					pins_next.column_strobe_n = ~cmd_next.byte_en;
					pins_next.dram_write_enable_n = ~cmd_next.write;
					pins_next.dram_output_enable_n = cmd_next.write;
				end
			end
			ST_STROBE: begin
				if (cmd_next.kind == emp_pkg::KIND_SPECIAL) begin
					// Address is set up a phase ahead so the strobe edge latches it
					if (cmd_next.write) begin
						pins_next.special_io_write_n[cmd_next.special_sel] = 1'b0;
					end else begin
						pins_next.special_io_read_n[cmd_next.special_sel] = 1'b0;
					end
				end else if (!cmd_next.write) begin
					pins_next.static_output_enable_n = 1'b0;
				end else if (cmd_next.kind != emp_pkg::KIND_ROM) begin
					pins_next.byte_write_enable_n = ~cmd_next.byte_en;
				end
			end
			ST_HOLD, ST_MSTR_WAIT, ST_MSTR_LATCH, ST_RELEASE: begin
				pins_next.static_addr_oe = 1'b0;
				pins_next.dram_addr_oe = 1'b0;
				pins_next.bus_hold_grant = (state_next != ST_RELEASE);
				pins_next.byte_write_enable_n = lanes_next;
				if (state_next == ST_MSTR_LATCH) begin
					pins_next.master_data_latch_n = 1'b0;
					pins_next.master_data_latch_oe = 1'b1;
				end
			end
			default: begin
				pins_next.static_addr_oe = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// State registers
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 3'h0;
			cmd_reg <= '0;
			mreq_reg <= '0;
			ready_reg <= 1'b0;
			done_reg <= 1'b0;
			mvalid_reg <= 1'b0;
			merr_reg <= 1'b0;
			pins_reg <= '{static_addr: 24'h000000, static_addr_oe: 1'b1,
				static_output_enable_n: 1'b1, byte_write_enable_n: emp_pkg::LANES_IDLE,
				dram_addr: 13'h0000, dram_addr_oe: 1'b1, row_strobe_n: emp_pkg::ROWS_IDLE,
				column_strobe_n: emp_pkg::LANES_IDLE, dram_output_enable_n: 1'b1,
				dram_write_enable_n: 1'b1, special_io_read_n: emp_pkg::SPECIAL_IDLE,
				special_io_write_n: emp_pkg::SPECIAL_IDLE, master_data_latch_n: 1'b1,
				master_data_latch_oe: 1'b0, bus_hold_grant: 1'b0};
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cmd_reg <= cmd_next;
			mreq_reg <= mreq_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			mvalid_reg <= mvalid_next;
			merr_reg <= merr_next;
			pins_reg <= pins_next;
		end
	end

	// ==========================================================
	// Outputs
	assign ACC_READY_OUT = ready_reg;
	assign ACC_DONE_OUT = done_reg;
	assign MASTER_REQ_VALID_OUT = mvalid_reg;
	assign MASTER_REQ_OUT = mreq_reg;
	assign MASTER_SIZE_ERROR_OUT = merr_reg;
	assign BUS_HOLD_GRANT_OUT = pins_reg.bus_hold_grant;
	assign STATIC_ADDR_OUT = pins_reg.static_addr;
	assign STATIC_ADDR_OE_OUT = pins_reg.static_addr_oe;
	assign STATIC_OUTPUT_ENABLE_N_OUT = pins_reg.static_output_enable_n;
	assign BYTE_WRITE_ENABLE_N_OUT = pins_reg.byte_write_enable_n;
	assign DRAM_ADDR_OUT = pins_reg.dram_addr;
	assign DRAM_ADDR_OE_OUT = pins_reg.dram_addr_oe;
	assign ROW_STROBE_N_OUT = pins_reg.row_strobe_n;
	assign COLUMN_STROBE_N_OUT = pins_reg.column_strobe_n;
	assign DRAM_OUTPUT_ENABLE_N_OUT = pins_reg.dram_output_enable_n;
	assign DRAM_WRITE_ENABLE_N_OUT = pins_reg.dram_write_enable_n;
	assign SPECIAL_IO_READ_N_OUT = pins_reg.special_io_read_n;
	assign SPECIAL_IO_WRITE_N_OUT = pins_reg.special_io_write_n;
	assign MASTER_DATA_LATCH_N_OUT = pins_reg.master_data_latch_n;
	assign MASTER_DATA_LATCH_OE_OUT = pins_reg.master_data_latch_oe;

endmodule // emp_port

`default_nettype wire

// ### verification/emp_master_model.sv
// External bus master model: hold request, address pins and data latch line.
// Assumes the bench resolves the latch line from the device's enable alone.
`timescale 1ns/1ps
`default_nettype none
module emp_master_model (
	input wire logic clk,
	output logic hold_req,
	output logic [23:0] addr_low,
	output logic [12:0] addr_pins,
	output logic latch_n
);
	initial begin
		hold_req = 1'b0;
		addr_low = 24'h0;
		addr_pins = 13'h0;
		latch_n = 1'b1;
	end
	// ==========================================================
	// Tasks
	task automatic request(input logic on);
		@(negedge clk);
		hold_req = on;
	endtask
	task automatic access(input logic [27:0] a, input logic burst, input logic rnw,
		input logic [1:0] size);
		// Let the device's own latch pulse clear the line before the next fall
		repeat (4) @(negedge clk);
		addr_low = a[23:0];
		addr_pins = 13'h0;
		addr_pins[emp_pkg::MA_HIGH_POS +: 4] = a[27:24];
		addr_pins[emp_pkg::MA_BURST_POS] = burst;
		addr_pins[emp_pkg::MA_RNW_POS] = rnw;
		addr_pins[emp_pkg::MA_SIZE_POS +: 2] = size;
		latch_n = 1'b0;
		repeat (4) @(negedge clk);
		latch_n = 1'b1;
		repeat (2) @(negedge clk);
		// Hold time over: show no stale value
		addr_low = ~addr_low;
		addr_pins = ~addr_pins;
	endtask
endmodule // emp_master_model
`default_nettype wire

// ### verification/emp_port_checker.sv
// Concurrent checks on the external memory port pins and handshakes.
// Assumes it is bound to emp_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module emp_port_checker (
	input wire logic REF_CLK_IN,
	input wire logic RESETN_IN,
	input wire logic ACC_REQ_IN,
	input wire emp_pkg::emp_cmd_t ACC_CMD_IN,
	input wire logic ACC_READY_OUT,
	input wire logic ACC_DONE_OUT,
	input wire logic MASTER_REQ_VALID_OUT,
	input wire logic MASTER_SIZE_ERROR_OUT,
	input wire logic BUS_HOLD_GRANT_OUT,
	input wire logic STATIC_ADDR_OE_OUT,
	input wire logic STATIC_OUTPUT_ENABLE_N_OUT,
	input wire logic [3:0] BYTE_WRITE_ENABLE_N_OUT,
	input wire logic DRAM_ADDR_OE_OUT,
	input wire logic [5:0] ROW_STROBE_N_OUT,
	input wire logic [3:0] COLUMN_STROBE_N_OUT,
	input wire logic DRAM_OUTPUT_ENABLE_N_OUT,
	input wire logic DRAM_WRITE_ENABLE_N_OUT,
	input wire logic [1:0] SPECIAL_IO_READ_N_OUT,
	input wire logic [1:0] SPECIAL_IO_WRITE_N_OUT,
	input wire logic MASTER_DATA_LATCH_N_OUT,
	input wire logic MASTER_DATA_LATCH_OE_OUT
);
	// ==========================================================
	// Sequences
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	sequence s_take;
		ACC_READY_OUT && ACC_REQ_IN && !BUS_HOLD_GRANT_OUT;
	endsequence
	sequence s_release;
		!STATIC_ADDR_OE_OUT && !DRAM_ADDR_OE_OUT ##1 STATIC_ADDR_OE_OUT && DRAM_ADDR_OE_OUT;
	endsequence
	sequence s_latch;
		!MASTER_DATA_LATCH_N_OUT && BUS_HOLD_GRANT_OUT && BYTE_WRITE_ENABLE_N_OUT != 4'hf
		##1 !MASTER_DATA_LATCH_OE_OUT;
	endsequence

	// ==========================================================
	// Assertions
	// Done is seen a fixed count of edges after the take edge
	a_dram_done_time: assert property (s_take ##0 ACC_CMD_IN.kind == emp_pkg::KIND_DRAM
		|-> ##1 (!ACC_DONE_OUT)[*6] ##1 ACC_DONE_OUT) else $error("dram done off time");
	a_static_done_time: assert property (s_take ##0 ACC_CMD_IN.kind != emp_pkg::KIND_DRAM
		|-> ##1 (!ACC_DONE_OUT)[*5] ##1 ACC_DONE_OUT) else $error("static done off time");
	a_grant_frees_pins: assert property (BUS_HOLD_GRANT_OUT |-> !STATIC_ADDR_OE_OUT && !DRAM_ADDR_OE_OUT)
		else $error("pins driven in hold");
	a_grant_when_idle: assert property ($rose(BUS_HOLD_GRANT_OUT) |-> ROW_STROBE_N_OUT == 6'h3f
		&& COLUMN_STROBE_N_OUT == 4'hf && STATIC_OUTPUT_ENABLE_N_OUT) else $error("grant mid access");
	a_release_order: assert property ($fell(BUS_HOLD_GRANT_OUT) |-> s_release)
		else $error("pins back too early");
	a_latch_pulse: assert property ($rose(MASTER_DATA_LATCH_OE_OUT) |-> s_latch)
		else $error("bad latch pulse");
	a_one_bank: assert property ($onehot0(~ROW_STROBE_N_OUT)) else $error("two row strobes");
	a_col_in_row: assert property (COLUMN_STROBE_N_OUT != 4'hf |-> ROW_STROBE_N_OUT != 6'h3f
		&& DRAM_ADDR_OE_OUT) else $error("column strobe without row");
	a_oe_we_apart: assert property (DRAM_OUTPUT_ENABLE_N_OUT || DRAM_WRITE_ENABLE_N_OUT)
		else $error("dram oe and we both low");
	a_special_one: assert property ($onehot0(~{SPECIAL_IO_READ_N_OUT, SPECIAL_IO_WRITE_N_OUT}))
		else $error("two special strobes");
	a_size_refused: assert property (MASTER_SIZE_ERROR_OUT |-> !MASTER_REQ_VALID_OUT
		&& BUS_HOLD_GRANT_OUT) else $error("bad size accepted");
endmodule // emp_port_checker

bind emp_port emp_port_checker u_emp_port_checker (.REF_CLK_IN, .RESETN_IN, .ACC_REQ_IN,
	.ACC_CMD_IN, .ACC_READY_OUT, .ACC_DONE_OUT, .MASTER_REQ_VALID_OUT, .MASTER_SIZE_ERROR_OUT,
	.BUS_HOLD_GRANT_OUT, .STATIC_ADDR_OE_OUT, .STATIC_OUTPUT_ENABLE_N_OUT, .BYTE_WRITE_ENABLE_N_OUT,
	.DRAM_ADDR_OE_OUT, .ROW_STROBE_N_OUT, .COLUMN_STROBE_N_OUT, .DRAM_OUTPUT_ENABLE_N_OUT,
	.DRAM_WRITE_ENABLE_N_OUT, .SPECIAL_IO_READ_N_OUT, .SPECIAL_IO_WRITE_N_OUT,
	.MASTER_DATA_LATCH_N_OUT, .MASTER_DATA_LATCH_OE_OUT);
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the external memory port.
// Assumes emp_port with the checker bound and the master model on its pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rst_n, acc_req, ready, done, m_valid, m_err, m_done, hold_req, grant;
	logic sa_oe, soe_n, da_oe, doe_n, dwe_n, dl_m, dl_out, dl_oe, dl_wire;
	logic [23:0] sa_in, sa_out;
	logic [12:0] da_in, da_out;
	logic [5:0] row_n;
	logic [3:0] col_n, bwe_n;
	logic [1:0] srd_n, swr_n;
	logic [20:0] pins;
	emp_pkg::emp_cmd_t acc_cmd;
	emp_pkg::emp_master_t m_req;
	int err_total = 0;
	int tests_run = 0;
	assign dl_wire = dl_oe ? dl_out : dl_m;
	assign pins = {row_n, col_n, bwe_n, soe_n, doe_n, dwe_n, srd_n, swr_n};

	emp_port u_emp_port (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .ACC_REQ_IN(acc_req),
		.ACC_CMD_IN(acc_cmd), .ACC_READY_OUT(ready), .ACC_DONE_OUT(done),
		.MASTER_REQ_VALID_OUT(m_valid), .MASTER_REQ_OUT(m_req), .MASTER_SIZE_ERROR_OUT(m_err),
		.MASTER_DONE_IN(m_done), .BUS_HOLD_REQUEST_IN(hold_req), .BUS_HOLD_GRANT_OUT(grant),
		.STATIC_ADDR_IN(sa_in), .STATIC_ADDR_OUT(sa_out), .STATIC_ADDR_OE_OUT(sa_oe),
		.STATIC_OUTPUT_ENABLE_N_OUT(soe_n), .BYTE_WRITE_ENABLE_N_OUT(bwe_n),
		.DRAM_ADDR_IN(da_in), .DRAM_ADDR_OUT(da_out), .DRAM_ADDR_OE_OUT(da_oe),
		.ROW_STROBE_N_OUT(row_n), .COLUMN_STROBE_N_OUT(col_n), .DRAM_OUTPUT_ENABLE_N_OUT(doe_n),
		.DRAM_WRITE_ENABLE_N_OUT(dwe_n), .SPECIAL_IO_READ_N_OUT(srd_n),
		.SPECIAL_IO_WRITE_N_OUT(swr_n), .MASTER_DATA_LATCH_N_IN(dl_wire),
		.MASTER_DATA_LATCH_N_OUT(dl_out), .MASTER_DATA_LATCH_OE_OUT(dl_oe));
	emp_master_model u_emp_master_model (.clk(clk), .hold_req(hold_req), .addr_low(sa_in),
		.addr_pins(da_in), .latch_n(dl_m));

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic emp_pkg::emp_cmd_t mk(emp_pkg::emp_kind_t k, logic w, logic [2:0] b,
		logic s, logic [3:0] e, logic [12:0] c, logic [23:0] a);
		return '{k, w, b, s, e, 13'h15a, c, a};
	endfunction
	// Strobes are ANDed over the whole access, so any lane that dips shows up
	task automatic run_acc(input emp_pkg::emp_cmd_t c, input logic [20:0] exp,
		input logic [23:0] exp_a);
		logic [20:0] seen;
		logic [23:0] a_seen;
		int n;
		seen = '1;
		a_seen = '0;
		for (n = 0; n < 20 && ready !== 1'b1; n++) @(negedge clk);
		acc_cmd = c;
		acc_req = 1'b1;
		@(negedge clk);
		acc_req = 1'b0;
		for (n = 0; n < 20 && done !== 1'b1; n++) begin
			seen = seen & pins;
			if (soe_n === 1'b0 || bwe_n !== 4'hf || {srd_n, swr_n} !== 4'hf) a_seen = sa_out;
			if (col_n !== 4'hf) a_seen = {11'h0, da_out};
			@(negedge clk);
		end
		check(done, 1'b1);
		check(seen, exp);
		check(a_seen, exp_a);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_dram();
		logic [3:0] e;
		for (int b = 0; b < 6; b++) begin
			e = 4'(b + 1);
			run_acc(mk(emp_pkg::KIND_DRAM, 1'b1, 3'(b), 1'b0, ~e, 13'(b + 9), 24'h0),
				{~(6'h1 << b), e, 4'hf, 3'b110, 4'hf}, 24'(b + 9));
			run_acc(mk(emp_pkg::KIND_DRAM, 1'b0, 3'(b), 1'b0, e, 13'h1f00, 24'h0),
				{~(6'h1 << b), ~e, 4'hf, 3'b101, 4'hf}, 24'h1f00);
		end
		$display("t_dram done");
	endtask
	task automatic t_static();
		run_acc(mk(emp_pkg::KIND_SRAM, 1'b1, 3'h0, 1'b0, 4'h5, 13'h0, 24'h123456),
			{10'h3ff, 4'ha, 3'b111, 4'hf}, 24'h123456);
		run_acc(mk(emp_pkg::KIND_EXT_IO, 1'b1, 3'h0, 1'b0, 4'ha, 13'h0, 24'h00beef),
			{10'h3ff, 4'h5, 3'b111, 4'hf}, 24'h00beef);
		run_acc(mk(emp_pkg::KIND_SRAM, 1'b0, 3'h0, 1'b0, 4'hf, 13'h0, 24'hfedcba),
			{10'h3ff, 4'hf, 3'b011, 4'hf}, 24'hfedcba);
		run_acc(mk(emp_pkg::KIND_ROM, 1'b1, 3'h0, 1'b0, 4'hf, 13'h0, 24'h800001),
			{10'h3ff, 4'hf, 3'b111, 4'hf}, 24'h0);
		for (int i = 0; i < 4; i++)
			run_acc(mk(emp_pkg::KIND_SPECIAL, i[1], 3'h0, i[0], 4'hf, 13'h0, 24'(i + 5)),
				{17'h1ffff, i[1] ? {2'h3, ~(2'h1 << i[0])} : {~(2'h1 << i[0]), 2'h3}},
				24'(i + 5));
		$display("t_static done");
	endtask
	task automatic t_hold();
		logic [27:0] a [3] = '{28'h9abcdee, 28'h1234561, 28'h0fedcb8};
		logic [1:0] sz [3] = '{2'h2, 2'h0, 2'h1};
		logic [3:0] lanes [3] = '{4'h3, 4'hd, 4'h0};
		int n;
		acc_cmd = mk(emp_pkg::KIND_DRAM, 1'b0, 3'h2, 1'b0, 4'hf, 13'h7, 24'h0);
		acc_req = 1'b1;
		@(negedge clk);
		acc_req = 1'b0;
		u_emp_master_model.request(1'b1);
		for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk);
		check(grant, 1'b0);
		for (n = 0; n < 20 && grant !== 1'b1; n++) @(negedge clk);
		check({grant, sa_oe, da_oe}, 3'b100);
		for (int i = 0; i < 3; i++) begin
			fork
				u_emp_master_model.access(a[i], i[0], i == 1, sz[i]);
				begin
					for (n = 0; n < 20 && m_valid !== 1'b1; n++) @(negedge clk);
					check(m_req, {a[i], i[0], i == 1, sz[i]});
				end
			join
			m_done = 1'b1;
			@(negedge clk);
			m_done = 1'b0;
			for (n = 0; n < 20 && dl_oe !== 1'b1; n++) @(negedge clk);
			check({dl_wire, bwe_n}, {1'b0, lanes[i]});
		end
		fork
			u_emp_master_model.access(28'h5555555, 1'b0, 1'b1, 2'h3);
			for (n = 0; n < 20 && m_err !== 1'b1; n++) @(negedge clk);
		join
		check(n < 20, 1'b1);
		u_emp_master_model.request(1'b0);
		for (n = 0; n < 20 && grant !== 1'b0; n++) @(negedge clk);
		check({grant, sa_oe}, 2'b00);
		@(negedge clk);
		check({sa_oe, da_oe}, 2'b11);
		$display("t_hold done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// Clock, reset, sequence, watchdog
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#1000000;
		err_total++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		acc_req = 1'b0;
		m_done = 1'b0;
		acc_cmd = '0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check({pins, grant, dl_oe}, {21'h1fffff, 2'b00});
		t_dram();
		t_static();
		t_hold();
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
